// File: core/uart_interrupt_combiner.sv
// interrupt generation and combining for a uart, AHB-Lite register slave
// assumes fifo levels, strobes and bit tick come from the uart, same clock
// bus side: zero wait states, a read just behind a write already sees it
`timescale 1ns/100ps
module uart_interrupt_combiner
  import uart_irq_pkg::*;
#(
  parameter int LEVEL_W = 5
) (
  input wire logic clock,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // uart side
  input wire modem_lines_t modem_lines,
  input wire rx_errors_t rx_errors,
  input wire logic fifo_enable,
  input wire logic [LEVEL_W:0] rx_level,
  input wire logic [LEVEL_W:0] rx_trigger,
  input wire logic [LEVEL_W:0] tx_level,
  input wire logic [LEVEL_W:0] tx_trigger,
  input wire logic rx_push,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic tx_empty,
  input wire logic bit_tick,
  // interrupt outputs
  output logic receive_irq,
  output logic transmit_irq,
  output logic rx_timeout_irq,
  output logic modem_status_irq,
  output logic error_irq,
  output logic combined_irq
);

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction

  logic [IRQ_W-1:0] mask_r;
  logic [IRQ_W-1:0] raw_r;
  logic [IRQ_W-1:0] raw_nxt;
  logic [IRQ_W-1:0] masked;
  logic [IRQ_W-1:0] set_ev;
  logic [IRQ_W-1:0] hw_clr;
  logic [IRQ_W-1:0] sw_clr;

  // bus data phase state
  logic wr_pend_r;
  logic [11:0] wr_addr_r;
  logic [31:0] rdata_r;
  logic hresp_r;
  logic hreadyout_r;
  logic addr_take;
  logic rd_take;
  logic wr_mask;
  logic wr_clear;
  logic [IRQ_W-1:0] mask_nxt;
  logic [IRQ_W-1:0] masked_nxt;

  assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ | htrans[1]);
  assign rd_take = addr_take & ~hwrite;
  assign wr_mask = wr_pend_r & hit(wr_addr_r, OFF_MASK);
  assign wr_clear = wr_pend_r & hit(wr_addr_r, OFF_CLEAR);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= addr_take & hwrite;
    end
  end

  // address held for the data phase, where the write lands
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_addr_r <= 12'h000;
    end else if (addr_take) begin
      wr_addr_r <= haddr;
    end
  end

  // zero wait state; OKAY for every access, unmapped reads give zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hreadyout_r <= 1'b1;
    end else begin
      hreadyout_r <= 1'b1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hresp_r <= 1'b0;
    end else begin
      hresp_r <= 1'b0;
    end
  end

  // read data sampled at the address edge, stands through the data phase;
  // next-state values, so a read right behind a write or a clear
  // in the data phase before it never returns stale bits
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      rdata_r <= 32'h0000_0000;
      if (hit(haddr, OFF_MASK)) begin
        rdata_r[IRQ_W-1:0] <= mask_nxt;
      end else if (hit(haddr, OFF_RAW)) begin
        rdata_r[IRQ_W-1:0] <= raw_nxt;
      end else if (hit(haddr, OFF_MASKED)) begin
        rdata_r[IRQ_W-1:0] <= masked_nxt;
      end
    end
  end

  always_comb begin
    mask_nxt = mask_r;
    if (wr_mask) begin
      mask_nxt = hwdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mask_r <= MASK_RESET;
    end else begin
      mask_r <= mask_nxt;
    end
  end

  // only ones written to the clear register act
  always_comb begin
    sw_clr = '0;
    if (wr_clear) begin
      sw_clr = hwdata[IRQ_W-1:0];
    end
  end

  // modem line change detection
  modem_lines_t modem_prev_r;
  modem_lines_t modem_change;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      modem_prev_r <= '1;
    end else begin
      modem_prev_r <= modem_lines;
    end
  end

  assign modem_change = modem_lines ^ modem_prev_r;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_modem
      assign set_ev[BIT_RING+gi] = modem_change[gi];
      assign hw_clr[BIT_RING+gi] = 1'b0;
    end
  endgenerate

  // receive: fifo mode by trigger crossing, single mode by char arrival
  logic rx_at_trig;
  logic rx_at_prev_r;
  logic rx_set;
  logic rx_hclr;

  assign rx_at_trig = (rx_level >= rx_trigger);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_at_prev_r <= 1'b0;
    end else begin
      rx_at_prev_r <= rx_at_trig;
    end
  end

  always_comb begin
    if (fifo_enable) begin
      rx_set = rx_at_trig & ~rx_at_prev_r;
      rx_hclr = ~rx_at_trig;
    end else begin
      rx_set = rx_push;
      rx_hclr = rx_pop;
    end
  end

  assign set_ev[BIT_RX] = rx_set;
  assign hw_clr[BIT_RX] = rx_hclr;

  // transmit: edge based, prev starts high so an idle empty buffer
  // at enable never raises the interrupt
  logic tx_at_trig;
  logic tx_at_prev_r;
  logic tx_empty_prev_r;
  logic tx_set;
  logic tx_hclr;

  assign tx_at_trig = (tx_level <= tx_trigger);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_at_prev_r <= 1'b1;
    end else begin
      tx_at_prev_r <= tx_at_trig;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_empty_prev_r <= 1'b1;
    end else begin
      tx_empty_prev_r <= tx_empty;
    end
  end

  always_comb begin
    if (fifo_enable) begin
      tx_set = tx_at_trig & ~tx_at_prev_r;
      tx_hclr = ~tx_at_trig;
    end else begin
      tx_set = tx_empty & ~tx_empty_prev_r;
      tx_hclr = tx_push;
    end
  end

  assign set_ev[BIT_TX] = tx_set;
  assign hw_clr[BIT_TX] = tx_hclr;

  // receive timeout: bit periods counted while data waits unread
  logic rx_nonempty;
  logic [RT_CNT_W-1:0] rt_cnt_r;
  logic rt_fire;
  logic rt_restart;
  logic rt_last;
  logic rt_full;

  assign rx_nonempty = (rx_level != '0);
  assign rt_restart = ~rx_nonempty | rx_push;
  assign rt_last = (rt_cnt_r == RT_CNT_W'(RT_BIT_PERIODS - 1));
  assign rt_full = (rt_cnt_r == RT_CNT_W'(RT_BIT_PERIODS));
  // saturating at the full count keeps one quiet spell to one event
  assign rt_fire = bit_tick & ~rt_restart & rt_last;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rt_cnt_r <= '0;
    end else if (rt_restart) begin
      rt_cnt_r <= '0;
    end else if (bit_tick & ~rt_full) begin
      rt_cnt_r <= rt_cnt_r + RT_CNT_W'(1);
    end
  end

  assign set_ev[BIT_RT] = rt_fire;
  assign hw_clr[BIT_RT] = ~rx_nonempty;

  // receive errors arrive as pulses from the receiver
  assign set_ev[BIT_OE] = rx_errors.overrun;
  assign set_ev[BIT_BE] = rx_errors.brk;
  assign set_ev[BIT_PE] = rx_errors.parity;
  assign set_ev[BIT_FE] = rx_errors.framing;
  assign hw_clr[BIT_FE +: 4] = 4'h0;

  // a new event outranks a clear in the same cycle
  function automatic logic [IRQ_W-1:0] sticky(input logic [IRQ_W-1:0] cur,
      input logic [IRQ_W-1:0] clr, input logic [IRQ_W-1:0] ev);
    sticky = (cur & ~clr) | ev;
  endfunction

  assign raw_nxt = sticky(raw_r, sw_clr | hw_clr, set_ev);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      raw_r <= RAW_RESET;
    end else begin
      raw_r <= raw_nxt;
    end
  end

  assign masked = raw_r & mask_r;
  assign masked_nxt = raw_nxt & mask_nxt;

  logic modem_any;
  logic error_any;

  // group requests, each the or of its masked sources
  assign modem_any = |masked[BIT_DSR:BIT_RING];
  assign error_any = |masked[BIT_OE:BIT_FE];

  // grouped outputs registered from masked status, one flop each
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      receive_irq <= 1'b0;
    end else begin
      receive_irq <= masked[BIT_RX];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      transmit_irq <= 1'b0;
    end else begin
      transmit_irq <= masked[BIT_TX];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rx_timeout_irq <= 1'b0;
    end else begin
      rx_timeout_irq <= masked[BIT_RT];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      modem_status_irq <= 1'b0;
    end else begin
      modem_status_irq <= modem_any;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      error_irq <= 1'b0;
    end else begin
      error_irq <= error_any;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      combined_irq <= 1'b0;
    end else begin
      combined_irq <= |masked;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = rdata_r;

endmodule // uart_interrupt_combiner

// File: core/uart_irq_pkg.sv
// constants and carrier types for the uart interrupt combiner
// assumes one 20 MHz clock and word-aligned AHB-Lite register access
package uart_irq_pkg;

  localparam int IRQ_W = 11;

  // source bit positions, shared by all status, mask and clear registers
  localparam int BIT_RING = 0;
  localparam int BIT_CTS = 1;
  localparam int BIT_DCD = 2;
  localparam int BIT_DSR = 3;
  localparam int BIT_RX = 4;
  localparam int BIT_TX = 5;
  localparam int BIT_RT = 6;
  localparam int BIT_FE = 7;
  localparam int BIT_PE = 8;
  localparam int BIT_BE = 9;
  localparam int BIT_OE = 10;

  // byte offsets
  localparam logic [11:0] OFF_MASK = 12'h000;
  localparam logic [11:0] OFF_RAW = 12'h004;
  localparam logic [11:0] OFF_MASKED = 12'h008;
  localparam logic [11:0] OFF_CLEAR = 12'h00C;

  localparam logic [IRQ_W-1:0] MASK_RESET = 11'h000;
  localparam logic [IRQ_W-1:0] RAW_RESET = 11'h000;

  // receive timeout span, in bit periods
  localparam int RT_BIT_PERIODS = 32;
  localparam int RT_CNT_W = 6;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic data_set_ready_n;
    logic carrier_detect_n;
    logic clear_to_send_n;
    logic ring_indicator_n;
  } modem_lines_t;

  typedef struct packed {
    logic overrun;
    logic brk;
    logic parity;
    logic framing;
  } rx_errors_t;

endpackage

// File: verification/irq_sink.sv
// interrupt controller stand-in: counts combined requests
// assumes a level request synchronous to clock
`timescale 1ns/100ps
module irq_sink (
  input wire logic clock,
  input wire logic rst,
  input wire logic irq,
  output logic [7:0] n_req
);
  logic irq_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_r <= 1'b0;
      n_req <= 8'h00;
    end else begin
      irq_r <= irq;
      if (irq && !irq_r) n_req <= n_req + 8'h01;
    end
  end
endmodule // irq_sink

// File: verification/uart_interrupt_combiner_test.sv
// bench for the interrupt combiner over AHB-Lite
// assumes zero-wait slave but waits on hready anyway
`timescale 1ns/100ps
module uart_interrupt_combiner_test import uart_irq_pkg::*;;
  logic clock = 0, rst = 1, hsel = 1, hwrite = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [11:0] haddr = 12'h000;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic hreadyout, hresp, fifo_enable = 0, bit_tick = 0;
  logic rx_push = 0, rx_pop = 0, tx_push = 0, tx_empty = 1;
  logic [5:0] rx_level = 0, rx_trigger = 4, tx_level = 10, tx_trigger = 2;
  modem_lines_t modem_lines = 4'hF;
  rx_errors_t rx_errors = 4'h0;
  logic receive_irq, transmit_irq, rx_timeout_irq, modem_status_irq;
  logic error_irq, combined_irq;
  logic [7:0] n_req;
  wire hready = hreadyout;
  int n_errors = 0, comparisons = 0;
  always #25 clock = ~clock;
  uart_interrupt_combiner dut_u (.clock, .rst, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
    .modem_lines, .rx_errors, .fifo_enable, .rx_level, .rx_trigger,
    .tx_level, .tx_trigger, .rx_push, .rx_pop, .tx_push, .tx_empty,
    .bit_tick, .receive_irq, .transmit_irq, .rx_timeout_irq,
    .modem_status_irq, .error_irq, .combined_irq);
  irq_sink sink_u (.clock, .rst, .irq(combined_irq), .n_req);
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wait_rdy;
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (hready !== 1'b1 && i < 20);
    if (hready !== 1'b1) begin
      n_errors++;
      print_verdict();
    end
  endtask
  task automatic bus(input logic [11:0] a, input logic w,
      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clock);
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(a, 1'b1, d, x);
  endtask
  task automatic rd_chk(input string n, input logic [11:0] a,
      input logic [31:0] e);
    logic [31:0] x;
    bus(a, 1'b0, 32'h0, x);
    chk(n, e, x);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clock);
      bit_tick <= 1'b1;
      @(posedge clock);
      bit_tick <= 1'b0;
    end
  endtask
  initial begin
    int b;
    repeat (20) @(posedge clock);
    rst <= 0;
    rd_chk("raw", OFF_RAW, 0);
    wr(OFF_MASK, 32'h7FF);
    rd_chk("mask", OFF_MASK, 32'h7FF);
    rd_chk("unmapped", 12'h010, 0);
    for (int j = 0; j < 8; j++) begin
      b = j < 4 ? j : j + 3;
      if (j < 4) modem_lines[j] <= ~modem_lines[j];
      else rx_errors[j-4] <= 1'b1;
      @(posedge clock);
      rx_errors <= 4'h0;
      rd_chk("raw", OFF_RAW, 32'h1 << b);
      rd_chk("masked", OFF_MASKED, 32'h1 << b);
      chk("groups", j < 4 ? 3 : 5, {error_irq, modem_status_irq,
        combined_irq});
      wr(OFF_CLEAR, 0);
      rd_chk("raw kept", OFF_RAW, 32'h1 << b);
      wr(OFF_CLEAR, 32'h1 << b);
      rd_chk("raw cleared", OFF_RAW, 0);
    end
    rx_push <= 1;
    @(posedge clock);
    rx_push <= 0;
    rd_chk("rx single", OFF_RAW, 32'h10);
    rx_pop <= 1;
    @(posedge clock);
    rx_pop <= 0;
    rd_chk("rx read", OFF_RAW, 0);
    tx_push <= 1;
    tx_empty <= 0;
    @(posedge clock);
    tx_push <= 0;
    tx_empty <= 1;
    rd_chk("tx single", OFF_RAW, 32'h20);
    tx_push <= 1;
    @(posedge clock);
    tx_push <= 0;
    rd_chk("tx write", OFF_RAW, 0);
    fifo_enable <= 1;
    rx_level <= 4;
    tx_level <= 2;
    rd_chk("fifo trig", OFF_RAW, 32'h30);
    chk("flow irqs", 3, {receive_irq, transmit_irq});
    rx_level <= 3;
    tx_level <= 3;
    rd_chk("fifo untrig", OFF_RAW, 0);
    ticks(31);
    rd_chk("31 ticks", OFF_RAW, 0);
    ticks(1);
    rd_chk("timeout", OFF_RAW, 32'h40);
    chk("timeout irq", 1, rx_timeout_irq);
    rx_level <= 0;
    rd_chk("empty", OFF_RAW, 0);
    chk("requests", 12, n_req);
    wr(OFF_MASK, 0);
    rx_errors <= 4'h1;
    @(posedge clock);
    rx_errors <= 4'h0;
    rd_chk("raw masked", OFF_RAW, 32'h80);
    rd_chk("masked off", OFF_MASKED, 0);
    chk("off irqs", 0, {error_irq, combined_irq});
    print_verdict();
  end
endmodule // uart_interrupt_combiner_test

// File: verification/uart_irq_sva.sv
// port assertions for the interrupt combiner
// assumes hready is the slave's own hreadyout fed back
`timescale 1ns/100ps
module uart_irq_sva
  import uart_irq_pkg::*;
#(
  parameter int LEVEL_W = 5
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire modem_lines_t modem_lines,
  input wire rx_errors_t rx_errors,
  input wire logic fifo_enable,
  input wire logic [LEVEL_W:0] rx_level,
  input wire logic [LEVEL_W:0] rx_trigger,
  input wire logic rx_pop,
  input wire logic rx_push,
  input wire logic tx_empty,
  input wire logic receive_irq,
  input wire logic transmit_irq,
  input wire logic rx_timeout_irq,
  input wire logic modem_status_irq,
  input wire logic error_irq,
  input wire logic combined_irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // mask shadow, snooped from bus writes
  logic [10:0] m_r;
  logic wm_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wm_r <= 1'b0;
      m_r <= 11'h000;
    end else if (hready) begin
      wm_r <= hsel && htrans[1] && hwrite && haddr == OFF_MASK;
      if (wm_r) m_r <= hwdata[10:0];
    end
  end
  sequence rx_low2;
    fifo_enable && rx_level < rx_trigger ##1
      fifo_enable && rx_level < rx_trigger;
  endsequence
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready okay");
  chk_comb_or: assert property (combined_irq == (receive_irq |
    transmit_irq | rx_timeout_irq | modem_status_irq | error_irq))
    else $error("combined irq not or of groups");
  chk_err_set: assert property (|(rx_errors & m_r[10:7]) |->
    ##2 error_irq) else $error("error irq missing");
  chk_modem_set: assert property (|((modem_lines ^
    $past(modem_lines)) & m_r[3:0]) |-> ##2 modem_status_irq)
    else $error("modem irq missing");
  chk_rx_low: assert property (rx_low2 |=> !receive_irq)
    else $error("receive irq below trigger");
  chk_timeout_clr: assert property ((rx_level == 0)[*2] |=>
    !rx_timeout_irq) else $error("timeout irq while empty");
  chk_tx_edge: assert property (!fifo_enable && $rose(tx_empty)
    && m_r[5] |-> ##2 transmit_irq) else $error("tx irq missing");
  chk_rx_pop: assert property (!fifo_enable && rx_pop && !rx_push
    |-> ##2 !receive_irq) else $error("receive irq kept after read");
  chk_mask_off: assert property (m_r[10:7] == 4'h0 |=>
    !error_irq) else $error("masked error reached output");
endmodule // uart_irq_sva

bind uart_interrupt_combiner uart_irq_sva #(.LEVEL_W(LEVEL_W)) sva_u (
  .clock, .rst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
  .hreadyout, .hresp, .modem_lines, .rx_errors, .fifo_enable,
  .rx_level, .rx_trigger, .rx_pop, .rx_push, .tx_empty, .receive_irq,
  .transmit_irq, .rx_timeout_irq, .modem_status_irq, .error_irq,
  .combined_irq);
